// File: hdl/cswc_top.sv
`timescale 1ns/1ps
`include "cswc_defines.svh"
//
// Summary of operation
// - Core clock is oscillator divided by two
// - Bus cycle is core clock divided by two
// - Stop halts oscillator, presets watchdog, selects f32
// - Source returns to select flag on MSB zero
// - Wake restarts oscillator, core waits watchdog MSB
// - Wait holds core low, oscillator keeps running
// - Stop works only when option is fitted
// - Stop wakes on limited set; wait on any
// - A wake interrupt or hardware reset ends stop or wait
// - Watchdog MSB clear raises interrupt, restores clock
//
module cswc_top
  import cswc_pkg::*;
#(
  parameter bit STOP_OPTION = 1'b1
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // Instruction decode
  input wire logic halt_oscillator_instruction,
  input wire logic idle_clock_instruction,
  // Wake requests, already gated by their enables
  input wire logic external_interrupt_line_0,
  input wire logic external_interrupt_line_1,
  input wire logic external_interrupt_line_2,
  input wire logic serial_ext_clock_irq,
  input wire logic timer_event_mode_irq,
  input wire logic other_hw_irq,
  // Watchdog control
  input wire logic wdt_freq_select,
  input wire logic wdt_restart,
  // Clocks and status
  output logic osc_enable,
  output logic core_clk,
  output logic bus_clk,
  output logic wdt_irq,
  output logic [`CSWC_WDT_W-1:0] wdt_count,
  output logic wdt_on_f32,
  output logic [1:0] power_state
);

  //////////////////////////////////////////////////////////////////////////
  // State and decode
  cswc_state_e state;
  cswc_state_e next_state;
  logic [4:0] presc;
  logic core_phase;
  logic [`CSWC_WAKE_W-1:0] wake;
  wire stop_go = halt_oscillator_instruction && STOP_OPTION;
  wire stop_entry;
  wire stop_wake;
  wire any_wake;
  wire msb_zero = ~wdt_count[`CSWC_WDT_MSB];
  wire [4:0] presc_top;
  wire tick;
  wire clk_run;
  wire [`CSWC_WDT_W-1:0] next_wdt;

  assign wake = {other_hw_irq, timer_event_mode_irq, serial_ext_clock_irq,
                 external_interrupt_line_2, external_interrupt_line_1,
                 external_interrupt_line_0};

  function automatic logic stop_wakeable(
    input logic [`CSWC_WAKE_W-1:0] w);
    stop_wakeable = w[`CSWC_WAKE_EXTERNAL_INTERRUPT_LINE_0] | w[`CSWC_WAKE_EXTERNAL_INTERRUPT_LINE_1] |
                    w[`CSWC_WAKE_EXTERNAL_INTERRUPT_LINE_2] | w[`CSWC_WAKE_SER_EXT] |
                    w[`CSWC_WAKE_TMR_EVT];
  endfunction

  assign stop_wake = stop_wakeable(wake);
  assign any_wake = |wake;
  assign stop_entry = (state == cswc_run) && stop_go;

  //////////////////////////////////////////////////////////////////////////
  // Power state sequencing
  always_comb begin
    next_state = state;
    case (state)
      cswc_run: begin
        if (stop_go) begin
          next_state = cswc_stop;
        end else if (idle_clock_instruction) begin
          next_state = cswc_wait;
        end
      end
      cswc_wait: begin
        if (any_wake) begin
          next_state = cswc_run;
        end
      end
      cswc_stop: begin
        if (stop_wake) begin
          next_state = cswc_settle;
        end
      end
      cswc_settle: begin
        // Oscillator is up but unsettled; core stays gated till MSB clears
        if (msb_zero) begin
          next_state = cswc_run;
        end
      end
      default: next_state = cswc_run;
    endcase
  end

  // Asynchronous reset is the only exit besides interrupts
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      state <= cswc_run;
    end else begin
      state <= next_state;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Watchdog prescaler and counter
  assign presc_top = wdt_on_f32 ? `CSWC_DIV_SLOW_W : `CSWC_DIV_FAST_W;
  // No ticks while the oscillator is off, so the count holds in stop
  assign tick = (presc == presc_top) && osc_enable;
  assign next_wdt = wdt_count - `CSWC_WDT_W'(1);

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      presc <= 5'h00;
    end else if (stop_entry) begin
      presc <= 5'h00;
    end else if (osc_enable) begin
      presc <= tick ? 5'h00 : presc + 5'h01;
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      wdt_count <= `CSWC_WDT_PRESET;
    end else if (stop_entry) begin
      wdt_count <= `CSWC_WDT_PRESET;
    end else if (wdt_restart && state == cswc_run) begin
      wdt_count <= `CSWC_WDT_PRESET;
    end else if (tick && state != cswc_stop) begin
      wdt_count <= next_wdt;
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      wdt_on_f32 <= 1'b0;
    end else if (stop_entry) begin
      wdt_on_f32 <= 1'b1;
    end else if (msb_zero) begin
      wdt_on_f32 <= wdt_freq_select;
    end else if (state == cswc_run) begin
      wdt_on_f32 <= wdt_freq_select;
    end
  end

  // One pulse as the MSB falls
  logic msb_prev;
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      msb_prev <= 1'b1;
    end else begin
      msb_prev <= wdt_count[`CSWC_WDT_MSB];
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      wdt_irq <= 1'b0;
    end else begin
      wdt_irq <= msb_prev & msb_zero;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Oscillator and clock outputs
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      osc_enable <= 1'b1;
    end else begin
      osc_enable <= (next_state != cswc_stop);
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      power_state <= 2'h0;
    end else begin
      power_state <= next_state;
    end
  end

  assign clk_run = (next_state == cswc_run);

  cswc_div2 u_core_div (
    .mclk(mclk),
    .rst_b(rst_b),
    .run(clk_run),
    .q(core_clk)
  );

  // Bus phase advances on each core falling edge
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      core_phase <= 1'b0;
      bus_clk <= 1'b0;
    end else begin
      core_phase <= core_clk;
      if (core_phase && !core_clk) begin
        bus_clk <= ~bus_clk;
      end
    end
  end

endmodule

// File: hdl/cswc_defines.svh
`ifndef CSWC_DEFINES_SVH
`define CSWC_DEFINES_SVH

// Watchdog width and preset loaded on stop
`define CSWC_WDT_W 12
`define CSWC_WDT_PRESET 12'hfff
`define CSWC_WDT_MSB 11
// Prescaler ratios of the two watchdog sources; the fast compare at 5'h10 divides by 17
`define CSWC_DIV_FAST 16
`define CSWC_DIV_SLOW 32
`define CSWC_DIV_FAST_W 5'h10
`define CSWC_DIV_SLOW_W 5'h1f
// Wake source vector layout
`define CSWC_WAKE_W 6
`define CSWC_WAKE_EXTERNAL_INTERRUPT_LINE_0 0
`define CSWC_WAKE_EXTERNAL_INTERRUPT_LINE_1 1
`define CSWC_WAKE_EXTERNAL_INTERRUPT_LINE_2 2
`define CSWC_WAKE_SER_EXT 3
`define CSWC_WAKE_TMR_EVT 4
`define CSWC_WAKE_OTHER 5

`endif

// File: hdl/cswc_pkg.sv
package cswc_pkg;
  typedef enum logic [1:0] {
    cswc_run,
    cswc_wait,
    cswc_stop,
    cswc_settle
  } cswc_state_e;
endpackage

// File: hdl/cswc_div2.sv
`timescale 1ns/1ps
// Divide-by-two toggle stage, gated low while halted.
module cswc_div2 (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // Control
  input wire logic run,
  // Output
  output logic q
);
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      q <= 1'b0;
    end else begin
      q <= run ? ~q : 1'b0;
    end
  end
endmodule

// File: verif/cswc_monitor.sv
`timescale 1ns/1ps
module cswc_monitor (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // Requests
  input wire logic halt_oscillator_instruction,
  input wire logic external_interrupt_line_0,
  input wire logic other_hw_irq,
  input wire logic wdt_freq_select,
  // Status
  input wire logic osc_enable,
  input wire logic core_clk,
  input wire logic bus_clk,
  input wire logic wdt_irq,
  input wire logic wdt_on_f32,
  input wire logic [11:0] wdt_count,
  input wire logic [1:0] power_state
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_b);
  ////////////////////////////////////////////////////////////
  core_div_a: assert property (
    (power_state == 2'h0)[*3] |-> $changed(core_clk))
    else $error("core clock stalled");
  bus_div_a: assert property (
    $changed(bus_clk) == ($past(core_clk, 2) && !$past(core_clk)
    && $past(rst_b)))
    else $error("bus clock off core fall");
  stop_entry_a: assert property (
    power_state == 2'h0 && halt_oscillator_instruction |=> power_state == 2'h2
    && !osc_enable && wdt_count == 12'hfff && wdt_on_f32)
    else $error("stop entry wrong");
  held_low_a: assert property (
    power_state != 2'h0 |-> !core_clk)
    else $error("core clock runs while halted");
  stop_wake_a: assert property (
    power_state == 2'h2 && external_interrupt_line_0 |=>
    power_state == 2'h3 && osc_enable)
    else $error("stop wake missed");
  wait_wake_a: assert property (
    power_state == 2'h1 && other_hw_irq |=> power_state == 2'h0)
    else $error("wait wake missed");
  settle_release_a: assert property (
    power_state == 2'h3 && !wdt_count[11] |=> power_state == 2'h0
    && wdt_irq && wdt_on_f32 == wdt_freq_select)
    else $error("settle release wrong");
  count_step_a: assert property (
    power_state == 2'h3 && $changed(wdt_count) |->
    wdt_count == $past(wdt_count) - 12'h1)
    else $error("watchdog step wrong");
  osc_halted_a: assert property (
    power_state == 2'h2 |-> !osc_enable)
    else $error("oscillator runs in stop");
  irq_pulse_a: assert property (
    wdt_irq |=> !wdt_irq)
    else $error("watchdog irq held");
  cover property (power_state == 2'h1);
  cover property (power_state == 2'h3 ##1 power_state == 2'h0);
  cover property (wdt_irq);
endmodule
bind cswc_top cswc_monitor mon (.mclk, .rst_b, .halt_oscillator_instruction,
  .external_interrupt_line_0, .other_hw_irq, .wdt_freq_select, .osc_enable,
  .core_clk, .bus_clk, .wdt_irq, .wdt_on_f32, .wdt_count, .power_state);

// File: verif/clock_stop_wait_control_test.sv
`timescale 1ns/1ps
module clock_stop_wait_control_test;
  logic mclk = 1'h0, rst_b = 1'h0, halt_oscillator_instruction = 1'h0;
  logic idle_clock_instruction = 1'h0, other_hw_irq = 1'h0;
  logic wdt_freq_select = 1'h0, wdt_restart = 1'h0;
  logic [4:0] wk = 5'h0;
  wire external_interrupt_line_0 = wk[0], external_interrupt_line_1 = wk[1];
  wire external_interrupt_line_2 = wk[2], serial_ext_clock_irq = wk[3];
  wire timer_event_mode_irq = wk[4];
  logic osc_enable, core_clk, bus_clk, wdt_irq, wdt_on_f32;
  logic [11:0] wdt_count;
  logic [1:0] power_state;
  int error_cnt, checked, cyc, n;
  cswc_top dut (.mclk, .rst_b, .halt_oscillator_instruction,
    .idle_clock_instruction, .external_interrupt_line_0,
    .external_interrupt_line_1, .external_interrupt_line_2,
    .serial_ext_clock_irq, .timer_event_mode_irq, .other_hw_irq,
    .wdt_freq_select, .wdt_restart, .osc_enable, .core_clk, .bus_clk,
    .wdt_irq, .wdt_count, .wdt_on_f32, .power_state);
  ////////////////////////////////////////////////////////////
  always #50 mclk = ~mclk;
  task automatic chk(string s, logic [11:0] v, logic [11:0] e);
    checked++;
    if (v !== e) begin
      error_cnt++;
      $display("unexpected %s: expected %h seen %h", s, e, v);
    end
  endtask
  task automatic halt;
    @(posedge mclk);
    @(posedge mclk) halt_oscillator_instruction <= 1'h1;
    @(posedge mclk) halt_oscillator_instruction <= 1'h0;
    #1;
    chk("state", power_state, 12'h2);
    chk("count", wdt_count, 12'hfff);
    chk("f32", wdt_on_f32, 12'h1);
  endtask
  task automatic t_wait;
    @(posedge mclk);
    @(posedge mclk) idle_clock_instruction <= 1'h1;
    @(posedge mclk) idle_clock_instruction <= 1'h0;
    repeat (4) @(posedge mclk);
    #1;
    chk("state", power_state, 12'h1);
    chk("osc", osc_enable, 12'h1);
    chk("core", core_clk, 12'h0);
    @(posedge mclk) other_hw_irq <= 1'h1;
    @(posedge mclk) other_hw_irq <= 1'h0;
    #1;
    chk("state", power_state, 12'h0);
    chk("core", core_clk, 12'h1);
    $display("wait test done");
  endtask
  task automatic t_wakes;
    for (int i = 0; i < 5; i++) begin
      halt();
      @(posedge mclk) wk <= 5'h1 << i;
      @(posedge mclk) wk <= 5'h0;
      #1;
      chk("state", power_state, 12'h3);
      @(posedge mclk) rst_b <= 1'h0;
      @(posedge mclk) rst_b <= 1'h1;
      #1;
      chk("state", power_state, 12'h0);
      chk("osc", osc_enable, 12'h1);
    end
    $display("wake test done");
  endtask
  task automatic t_stop;
    halt();
    @(posedge mclk) other_hw_irq <= 1'h1;
    @(posedge mclk) other_hw_irq <= 1'h0;
    #1;
    chk("state", power_state, 12'h2);
    @(posedge mclk) wk <= 5'h2;
    @(posedge mclk) wk <= 5'h0;
    #1;
    chk("osc", osc_enable, 12'h1);
    n = 0;
    while (power_state !== 2'h0 && n < 70000) begin
      @(posedge mclk);
      #1;
      n++;
    end
    chk("settle", 12'(n >= 65530 && n <= 65600), 12'h1);
    chk("f32", wdt_on_f32, 12'h0);
    chk("count", wdt_count, 12'h7ff);
    chk("irq", wdt_irq, 12'h1);
    chk("core", core_clk, 12'h1);
    @(posedge mclk);
    #1;
    chk("irq", wdt_irq, 12'h0);
    $display("stop test done");
  endtask
  task automatic t_clocks;
    logic pc, pb;
    int nc, nb;
    nc = 0;
    nb = 0;
    repeat (3) @(posedge mclk);
    #1;
    pc = core_clk;
    pb = bus_clk;
    repeat (8) begin
      @(posedge mclk);
      #1;
      if (core_clk !== pc) nc++;
      if (bus_clk !== pb) nb++;
      pc = core_clk;
      pb = bus_clk;
    end
    chk("core toggles", 12'(nc), 12'h8);
    chk("bus toggles", 12'(nb), 12'h4);
    $display("clock test done");
  endtask
  task automatic t_watchdog;
    @(posedge mclk) wdt_freq_select <= 1'h1;
    @(posedge mclk) wdt_restart <= 1'h1;
    @(posedge mclk) wdt_restart <= 1'h0;
    #1;
    chk("f32", wdt_on_f32, 12'h1);
    chk("count", wdt_count, 12'hfff);
    @(posedge mclk) wdt_freq_select <= 1'h0;
    @(posedge mclk);
    #1;
    chk("f32", wdt_on_f32, 12'h0);
    $display("watchdog test done");
  endtask
  task automatic summarize;
    $display("checked %0d error_cnt %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 90000) begin
      error_cnt++;
      summarize();
    end
  end
  initial begin
    repeat (20) @(posedge mclk);
    rst_b <= 1'h1;
    #1;
    chk("count", wdt_count, 12'hfff);
    t_wait();
    t_clocks();
    t_watchdog();
    t_wakes();
    t_stop();
    summarize();
  end
endmodule
